// >>> ccp_slave.sv
// Codec control port: two-wire slave with switch to four-wire mode
//
// How it works
// - Starts two-wire; three select lows switch four-wire.
// - Mode switch accepted any time after reset.
// - Four-wire kept until power-down pin low.
// - Frame: address/direction, two subaddress bytes, data.
// - One byte per location; pointer advances per byte.
// - Reserved locations read back zero.
// - Auto-increment runs until stop or select high.
// - Slave only; never drives the clock.
// - Slave address 01111 plus two strap bits.
// - First byte LSB: one reads, zero writes.
// - Start is data falling, clock high; MSB first.
// - Stop is data rising, clock high; ends transfer.
// - Matching address acknowledged on ninth clock, else idle.
// - Stray stop forces idle at once; stray start restarts the frame.
// - Invalid subaddress: no acknowledge, back to idle.
// - Reads past the end repeat the last register.
// - Writes past the end: dropped, no acknowledge, idle.
// - Three mode-switch frames ignored; fourth accepted.
// - Every in-range written byte acknowledged on ninth clock.
`timescale 1ns/10ps
module ccp_slave #(
  parameter int NUM_REGS = ccp_pkg::NUM_REGS_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_address_strap_bit0,
  input wire logic i_address_strap_bit1,
  input wire logic i_power_down_pin_n,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_spi_mode,
  output logic o_reg_write_valid,
  output ccp_pkg::ccp_wr_t o_reg_write
);

  localparam int AW = (NUM_REGS > 2) ? $clog2(NUM_REGS) : 1;
  localparam logic [15:0] NUM_REGS_W = 16'(NUM_REGS);
  localparam logic [15:0] LAST_SUB = 16'(NUM_REGS - 1);

  if (NUM_REGS < 2 || NUM_REGS > ccp_pkg::NUM_REGS_MAX) begin : g_chk
    $error("NUM_REGS out of range");
  end

  function automatic logic sub_valid(input logic [15:0] sub);
    return sub < NUM_REGS_W;
  endfunction

  function automatic logic sub_reserved(input logic [15:0] sub);
    return (sub >= ccp_pkg::RSVD_LO) && (sub <= ccp_pkg::RSVD_HI);
  endfunction

  // Pointer stops one past the top so the overrun is still seen
  function automatic logic [15:0] sub_step(input logic [15:0] sub);
    return sub_valid(sub) ? sub + ccp_pkg::SUB_ONE : sub;
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  ccp_pkg::ccp_pins_t pins_raw;
  ccp_pkg::ccp_pins_t sync1;
  ccp_pkg::ccp_pins_t sync2;
  ccp_pkg::ccp_pins_t prev;

  assign pins_raw = '{scl: i_scl, sda: i_sda, ss: i_address_strap_bit0,
                      mosi: i_address_strap_bit1, pd_n: i_power_down_pin_n};

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= '1;
      sync2 <= '1;
      prev <= '1;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic ss_fall;
  logic ss_rise;
  logic i2c_start;
  logic i2c_stop;
  logic [6:0] own_addr;

  assign scl_rise = sync2.scl & ~prev.scl;
  assign scl_fall = ~sync2.scl & prev.scl;
  assign ss_fall = ~sync2.ss & prev.ss;
  assign ss_rise = sync2.ss & ~prev.ss;
  assign i2c_start = sync2.scl & prev.scl & prev.sda & ~sync2.sda;
  assign i2c_stop = sync2.scl & prev.scl & ~prev.sda & sync2.sda;
  assign own_addr = {ccp_pkg::I2C_ADDR_HI, sync2.mosi, sync2.ss};

  ccp_pkg::ccp_state_t state;
  ccp_pkg::ccp_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic rw;
  logic next_rw;
  logic [15:0] sub;
  logic [15:0] next_sub;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic spi_mode;
  logic next_spi_mode;
  logic [1:0] ss_falls;
  logic [1:0] next_ss_falls;
  logic sda_out;
  logic next_sda_out;
  logic sda_oe;
  logic next_sda_oe;
  logic wr_valid;
  logic next_wr_valid;
  ccp_pkg::ccp_wr_t wr;
  ccp_pkg::ccp_wr_t next_wr;

  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;

  // Reads beyond the top keep returning the last register
  assign rd_addr = sub_valid(sub) ? sub[AW-1:0] : LAST_SUB[AW-1:0];

  ccp_regmem #(
    .AW(AW),
    .DEPTH(NUM_REGS)
  ) u_mem (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_wr_en(wr_valid),
    .i_wr_addr(wr.addr[AW-1:0]),
    .i_wr_data(wr.data),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data)
  );

  always_comb begin
    logic byte_done;
    logic [7:0] byte_in;
    logic ack;
    logic fail;
    byte_done = 1'b0;
    byte_in = shreg;
    ack = 1'b0;
    fail = 1'b0;
    next_state = state;
    next_bitcnt = bitcnt;
    next_byte_idx = byte_idx;
    next_rw = rw;
    next_sub = sub;
    next_shreg = shreg;
    next_spi_mode = spi_mode;
    next_ss_falls = ss_falls;
    next_wr_valid = 1'b0;
    next_wr = wr;

    if (!sync2.pd_n) begin
      next_spi_mode = 1'b0;
      next_ss_falls = 2'h0;
      next_state = ccp_pkg::ST_IDLE;
    end else if (!spi_mode) begin
      // Counted at any time, even mid-transfer
      if (ss_fall && ss_falls != ccp_pkg::SS_FALLS_TO_SPI) begin
        next_ss_falls = ss_falls + 2'h1;
      end
      // Switch on the third release, so that frame is ignored too
      if (ss_rise && ss_falls == ccp_pkg::SS_FALLS_TO_SPI) begin
        next_spi_mode = 1'b1;
        next_state = ccp_pkg::ST_IDLE;
      end else if (i2c_stop) begin
        next_state = ccp_pkg::ST_IDLE;
      end else if (i2c_start) begin
        next_state = ccp_pkg::ST_RX;
        next_bitcnt = 4'h0;
        next_byte_idx = ccp_pkg::BYTE_DEVADDR;
      end else begin
        case (state)
          ccp_pkg::ST_RX: begin
            if (scl_rise) begin
              next_shreg = {shreg[6:0], sync2.sda};
              next_bitcnt = bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == ccp_pkg::BITS_PER_BYTE) begin
              byte_done = 1'b1;
            end
          end
          ccp_pkg::ST_ACK: begin
            if (scl_fall) begin
              next_bitcnt = 4'h0;
              if (rw) begin
                next_shreg = rd_data;
                next_sub = sub_step(sub);
                next_state = ccp_pkg::ST_TX;
              end else begin
                next_state = ccp_pkg::ST_RX;
              end
            end
          end
          ccp_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == ccp_pkg::LAST_BIT) begin
                next_bitcnt = 4'h0;
                next_state = ccp_pkg::ST_RACK;
              end else begin
                next_shreg = {shreg[6:0], 1'b0};
                next_bitcnt = bitcnt + 4'h1;
              end
            end
          end
          ccp_pkg::ST_RACK: begin
            // Master no-acknowledge ends the read
            if (scl_rise && sync2.sda) begin
              next_state = ccp_pkg::ST_IDLE;
            end else if (scl_fall) begin
              next_shreg = rd_data;
              next_sub = sub_step(sub);
              next_state = ccp_pkg::ST_TX;
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      if (sync2.ss) begin
        next_state = ccp_pkg::ST_IDLE;
      end else if (ss_fall) begin
        next_state = ccp_pkg::ST_RX;
        next_bitcnt = 4'h0;
        next_byte_idx = ccp_pkg::BYTE_DEVADDR;
      end else begin
        case (state)
          ccp_pkg::ST_RX: begin
            if (scl_rise) begin
              next_shreg = {shreg[6:0], sync2.mosi};
              if (bitcnt == ccp_pkg::LAST_BIT) begin
                byte_done = 1'b1;
                byte_in = {shreg[6:0], sync2.mosi};
                next_bitcnt = 4'h0;
              end else begin
                next_bitcnt = bitcnt + 4'h1;
              end
            end
          end
          ccp_pkg::ST_TX: begin
            // Read data shifts out on falling clock
            if (scl_fall) begin
              if (bitcnt == 4'h0) begin
                next_shreg = rd_data;
                next_sub = sub_step(sub);
              end else begin
                next_shreg = {shreg[6:0], 1'b0};
              end
              next_bitcnt = (bitcnt == ccp_pkg::LAST_BIT) ? 4'h0
                                                          : bitcnt + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (byte_done) begin
      case (byte_idx)
        ccp_pkg::BYTE_DEVADDR: begin
          next_rw = byte_in[0];
          if (!spi_mode && byte_in[7:1] != own_addr) begin
            fail = 1'b1;
          end else begin
            ack = 1'b1;
          end
        end
        ccp_pkg::BYTE_SUBHI: begin
          next_sub = {byte_in, sub[7:0]};
          ack = 1'b1;
        end
        ccp_pkg::BYTE_SUBLO: begin
          next_sub = {sub[15:8], byte_in};
          if (!sub_valid({sub[15:8], byte_in})) begin
            fail = 1'b1;
          end else begin
            ack = 1'b1;
          end
        end
        default: begin
          if (!sub_valid(sub)) begin
            fail = 1'b1;
          end else begin
            // Reserved locations keep zero so they read back zero
            next_wr_valid = !sub_reserved(sub);
            next_wr = '{addr: sub, data: byte_in};
            next_sub = sub_step(sub);
            ack = 1'b1;
          end
        end
      endcase
      if (byte_idx != ccp_pkg::BYTE_DATA) begin
        next_byte_idx = byte_idx + 2'h1;
      end
      if (fail) begin
        next_state = spi_mode ? ccp_pkg::ST_HOLD : ccp_pkg::ST_IDLE;
      end else if (ack && !spi_mode) begin
        next_state = ccp_pkg::ST_ACK;
        next_bitcnt = 4'h0;
      end else if (ack && rw && byte_idx == ccp_pkg::BYTE_SUBLO) begin
        next_state = ccp_pkg::ST_TX;
      end else begin
        next_state = ccp_pkg::ST_RX;
      end
    end

    // Pin drive; two-wire mode only ever pulls low
    next_sda_out = 1'b0;
    next_sda_oe = 1'b0;
    if (next_state == ccp_pkg::ST_ACK && !next_spi_mode) begin
      next_sda_oe = 1'b1;
    end else if (next_state == ccp_pkg::ST_TX) begin
      if (next_spi_mode) begin
        next_sda_out = next_shreg[7];
        next_sda_oe = 1'b1;
      end else begin
        next_sda_oe = ~next_shreg[7];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ccp_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      byte_idx <= ccp_pkg::BYTE_DEVADDR;
      rw <= 1'b0;
      sub <= 16'h0000;
      shreg <= ccp_pkg::BYTE_ZERO;
      spi_mode <= 1'b0;
      ss_falls <= 2'h0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_valid <= 1'b0;
      wr <= '0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      byte_idx <= next_byte_idx;
      rw <= next_rw;
      sub <= next_sub;
      shreg <= next_shreg;
      spi_mode <= next_spi_mode;
      ss_falls <= next_ss_falls;
      sda_out <= next_sda_out;
      sda_oe <= next_sda_oe;
      wr_valid <= next_wr_valid;
      wr <= next_wr;
    end
  end

  assign o_sda = sda_out;
  assign o_sda_oe = sda_oe;
  assign o_spi_mode = spi_mode;
  assign o_reg_write_valid = wr_valid;
  assign o_reg_write = wr;

endmodule

// >>> ccp_pkg.sv
// Shared constants and types for the codec control port slave
package ccp_pkg;

  localparam int SUB_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_REGS_DEFAULT = 64;
  localparam int NUM_REGS_MAX = 65535;

  // Fixed upper part of the 7-bit slave address
  localparam logic [4:0] I2C_ADDR_HI = 5'h0f;

  // Chip-select low pulses that switch the port to four-wire mode
  localparam logic [1:0] SS_FALLS_TO_SPI = 2'h3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Byte positions within a frame
  localparam logic [1:0] BYTE_DEVADDR = 2'h0;
  localparam logic [1:0] BYTE_SUBHI = 2'h1;
  localparam logic [1:0] BYTE_SUBLO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  // Reserved register locations: writes dropped, reads give zero
  localparam logic [15:0] RSVD_LO = 16'h0030;
  localparam logic [15:0] RSVD_HI = 16'h0033;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] SUB_ONE = 16'h0001;

  typedef struct packed {
    logic scl;
    logic sda;
    logic ss;
    logic mosi;
    logic pd_n;
  } ccp_pins_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } ccp_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK,
    ST_HOLD
  } ccp_state_t;

endpackage

// >>> ccp_regmem.sv
// Byte-wide register storage with a registered read port
`timescale 1ns/10ps
module ccp_regmem #(
  parameter int AW = 6,
  parameter int DEPTH = 64
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);

  logic [7:0] mem [DEPTH];

  // Cleared at reset so reserved and unwritten locations read zero
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
      o_rd_data <= 8'h00;
    end else begin
      if (i_wr_en) begin
        mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// >>> ccp_slave_checker.sv
// Concurrent checks on the control port slave pins
`timescale 1ns/10ps
module ccp_slave_checker #(
  parameter int NUM_REGS = 64
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_address_strap_bit0,
  input wire logic i_address_strap_bit1,
  input wire logic i_power_down_pin_n,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_spi_mode,
  input wire logic o_reg_write_valid,
  input wire ccp_pkg::ccp_wr_t o_reg_write
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Long enough to pass the pin synchroniser
  sequence pd_held_high;
    i_power_down_pin_n [*6];
  endsequence
  sequence pd_held_low;
    !i_power_down_pin_n [*6];
  endsequence
  sequence ss_parked;
    i_address_strap_bit0 [*6];
  endsequence
  a_wr_single: assert property (
    o_reg_write_valid |=> !o_reg_write_valid)
    else $error("write pulse longer than one cycle");
  a_wr_in_map: assert property (
    o_reg_write_valid |-> o_reg_write.addr < NUM_REGS &&
    !(o_reg_write.addr inside {[ccp_pkg::RSVD_LO:ccp_pkg::RSVD_HI]}))
    else $error("write to reserved or missing location");
  a_mode_kept: assert property (
    pd_held_high ##0 o_spi_mode |=> o_spi_mode)
    else $error("four-wire mode lost without power-down");
  a_pd_exit: assert property (pd_held_low |-> !o_spi_mode)
    else $error("four-wire mode kept during power-down");
  a_open_drain: assert property (
    !o_spi_mode && !$past(o_spi_mode) |-> !o_sda)
    else $error("data line driven high in two-wire mode");
  a_oe_scl_low: assert property (
    !o_spi_mode && $changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  a_ack_holds: assert property (
    !o_spi_mode && $rose(o_sda_oe) |=> o_sda_oe [*4])
    else $error("acknowledge drive too short");
  a_spi_quiet: assert property (
    ss_parked ##0 o_spi_mode |-> !o_sda_oe)
    else $error("output driven while not selected");
endmodule

// >>> ccp_host_model.sv
// Behavioural host: two-wire master and four-wire frames
`timescale 1ns/10ps
module ccp_host_model (
  input wire logic i_clock,
  input wire logic i_sda,
  input wire logic i_miso,
  output logic o_scl,
  output logic o_sda_low,
  output logic o_ss,
  output logic o_mosi
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_ss = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    o_sda_low = !b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl = 1'b0;
  endtask
  // Only one start in a clock high
  task automatic start();
    tick(2);
    o_sda_low = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b0;
  endtask
  // Closes a transfer with a stop; rd3 and t_stray also restart with a start
  task automatic stop();
    tick(2);
    o_sda_low = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b0;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic sack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    // Host acks read bytes, refuses the last
    bit_io(mack, r);
    sack = !r;
  endtask
  // Select low for the whole frame, clock idles low
  // Read data taken just before each falling clock
  task automatic spi_frame(input logic [31:0] w, output logic [31:0] r);
    o_scl = 1'b0;
    o_ss = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      o_mosi = w[i];
      tick(4);
      o_scl = 1'b1;
      tick(4);
      r[i] = i_miso;
      o_scl = 1'b0;
    end
    tick(4);
    o_ss = 1'b1;
    o_mosi = 1'b0;
    tick(8);
  endtask
endmodule

// >>> ccp_slave_bench.sv
// Self-checking bench for the control port slave
`timescale 1ns/10ps
module ccp_slave_bench;
  localparam int NREGS = 64;
  logic i_clock, i_resetn, pd_n, scl, sda_low, ss, mosi;
  logic sda_o, sda_oe, spi_mode, wr_valid;
  ccp_pkg::ccp_wr_t wr;
  ccp_pkg::ccp_wr_t wq[$];
  int fails = 0;
  int check_count = 0;
  // Pull-up wins unless someone pulls low
  wire sda_wire = !((sda_oe && !spi_mode) || sda_low);
  // Four-wire read line floats unless driven
  wire miso = sda_oe ? sda_o : 1'bz;
  ccp_slave #(.NUM_REGS(NREGS)) dut (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_wire),
    .i_address_strap_bit0(ss), .i_address_strap_bit1(mosi),
    .i_power_down_pin_n(pd_n), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .o_spi_mode(spi_mode), .o_reg_write_valid(wr_valid),
    .o_reg_write(wr));
  ccp_host_model host (.i_clock(i_clock), .i_sda(sda_wire),
    .i_miso(miso), .o_scl(scl),
    .o_sda_low(sda_low), .o_ss(ss), .o_mosi(mosi));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (wr_valid === 1'b1) wq.push_back(wr);
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({23'h0, got}, {23'h0, exp});
  endtask
  task automatic exp_wr(input logic [23:0] e);
    chk_bit(wq.size() != 0, 1'b1);
    if (wq.size() != 0) chk_val(wq.pop_front(), e);
  endtask
  // Address 0x3d: strap bit0 high, bit1 low
  task automatic send(input logic [79:0] bs, input int n,
                      output logic [9:0] acks);
    logic [7:0] rx;
    acks = 10'h000;
    host.start();
    for (int k = 0; k < n; k++) begin
      host.xfer(bs[8*(n-1-k) +: 8], 1'b1, rx, acks[k]);
    end
  endtask
  task automatic rd3(input logic [15:0] sub, input logic [23:0] e);
    logic [9:0] a;
    logic [7:0] rx;
    logic k;
    send({56'h0, 8'h7a, sub}, 3, a);
    send(80'h7b, 1, a);
    chk_bit(a[0], 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.xfer(8'hff, i == 2, rx, k);
      chk_val({16'h0, rx}, {16'h0, e[23-8*i -: 8]});
    end
    host.stop();
  endtask
  task automatic t_burst();
    logic [9:0] a;
    // Zeros over the reserved span
    send(80'h7a002fb200000000c7, 9, a);
    host.stop();
    chk_val({14'h0, a}, 24'h1ff);
    exp_wr(24'h002fb2);
    exp_wr(24'h0034c7);
    chk_bit(wq.size() == 0, 1'b1);
    rd3(16'h002f, 24'hb20000);
    $display("burst done");
  endtask
  task automatic t_addr();
    logic [9:0] a;
    logic [7:0] ad [4] = '{8'h78, 8'h7a, 8'h7c, 8'h7e};
    foreach (ad[i]) begin
      send({72'h0, ad[i]}, 1, a);
      host.stop();
      chk_bit(a[0], ad[i] == 8'h7a);
    end
    send(80'h7a004055, 4, a);
    host.stop();
    chk_val({14'h0, a}, 24'h003);
    chk_bit(wq.size() == 0, 1'b1);
    $display("address done");
  endtask
  task automatic t_top();
    logic [9:0] a;
    send(80'h7a003e112233, 6, a);
    host.stop();
    chk_val({14'h0, a}, 24'h01f);
    exp_wr(24'h003e11);
    exp_wr(24'h003f22);
    chk_bit(wq.size() == 0, 1'b1);
    rd3(16'h003e, 24'h112222);
    $display("top done");
  endtask
  task automatic t_stray();
    logic [9:0] a;
    logic r;
    send(80'h7a00, 2, a);
    for (int i = 0; i < 3; i++) host.bit_io(1'b0, r);
    send(80'h7a000766, 4, a);
    host.stop();
    chk_val({14'h0, a}, 24'h00f);
    exp_wr(24'h000766);
    send(80'h7a0008, 3, a);
    for (int i = 0; i < 4; i++) host.bit_io(i[0], r);
    host.stop();
    chk_bit(wq.size() == 0, 1'b1);
    $display("stray done");
  endtask
  task automatic t_spi();
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      chk_bit(spi_mode, 1'b0);
      host.spi_frame(32'h00000577, r);
    end
    chk_bit(spi_mode, 1'b1);
    chk_bit(wq.size() == 0, 1'b1);
    host.spi_frame(32'h00000511, r);
    exp_wr(24'h000511);
    host.spi_frame(32'h01000500, r);
    chk_val({16'h0, r[7:0]}, 24'h000011);
    chk_bit(sda_oe, 1'b0);
    host.spi_frame(32'h00004099, r);
    chk_bit(wq.size() == 0, 1'b1);
    chk_bit(spi_mode, 1'b1);
    pd_n = 1'b0;
    host.tick(8);
    chk_bit(spi_mode, 1'b0);
    pd_n = 1'b1;
    host.tick(8);
    $display("four-wire done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    i_resetn = 1'b0;
    pd_n = 1'b1;
    repeat (3) @(posedge i_clock);
    #2;
    i_resetn = 1'b1;
    host.tick(6);
    t_burst();
    t_addr();
    t_top();
    t_stray();
    t_spi();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge i_clock);
    fails++;
    end_sim();
  end
endmodule
bind ccp_slave ccp_slave_checker #(.NUM_REGS(NUM_REGS)) u_chk (.i_clock,
  .i_resetn, .i_scl, .i_sda, .i_address_strap_bit0, .i_address_strap_bit1,
  .i_power_down_pin_n, .o_sda, .o_sda_oe, .o_spi_mode, .o_reg_write_valid,
  .o_reg_write);
